// ==== logic/qp_pkg.sv ====
package qp_pkg;
	// Command byte field positions, most significant bit shifted first.
	localparam int ADDR_HI = 7;
	localparam int ADDR_LO = 4;
	localparam int OPC_HI = 3;
	localparam int OPC_LO = 2;
	localparam int D8_POS = 1;
	// Opcode encodings.
	localparam logic [1:0] OPC_WRITE = 2'h0;
	localparam logic [1:0] OPC_INCR = 2'h1;
	localparam logic [1:0] OPC_DECR = 2'h2;
	localparam logic [1:0] OPC_READ = 2'h3;
	// Register addresses.
	localparam logic [3:0] ADR_WIPER0 = 4'h0;
	localparam logic [3:0] ADR_WIPER1 = 4'h1;
	localparam logic [3:0] ADR_TCON0 = 4'h4;
	localparam logic [3:0] ADR_WIPER2 = 4'h6;
	localparam logic [3:0] ADR_WIPER3 = 4'h7;
	localparam logic [3:0] ADR_TCON1 = 4'hA;
	// Register width and scale limits.
	localparam int REG_W = 9;
	localparam logic [8:0] FULL_SCALE = 9'h100;
	localparam logic [8:0] ZERO_SCALE = 9'h000;
	localparam logic [8:0] WIPER_RESET = 9'h080;
	localparam logic [8:0] TERMINAL_CONNECT_REG_RESET = 9'h1FF;
	// Frame bit counts.
	localparam logic [4:0] BITS_SHORT = 5'h08;
	localparam logic [4:0] BITS_LONG = 5'h10;
	localparam logic [4:0] ERR_BIT = 5'h06;
	// Master timing: half serial period and select-to-clock delay.
	localparam int SCK_HALF_NS = 40;
	localparam int CLK_NS = 5;
	localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;
	localparam int LEAD_NS = 100;
	localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== logic/qp_if.sv ====
`timescale 1ns/1ps
interface qp_if;
	logic cs_b; // Chip select, active low.
	logic cs_hv; // Chip select at the high-voltage level.
	logic sck; // Serial clock from master.
	logic mosi; // Data to device.
	logic miso; // Data from device.
	logic miso_oe; // Device drives miso.
	modport device (input cs_b, input cs_hv, input sck, input mosi,
		output miso, output miso_oe);
	modport master (output cs_b, output cs_hv, output sck, output mosi,
		input miso, input miso_oe);
endinterface // qp_if

// ==== logic/qp_device.sv ====
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// How it works
// - Master starts frames by asserting chip select.
// - Select asserts output drive and clears counter.
// - Master waits before first serial clock edge.
// - Error drives flag low until deselect.
// - Deselect resets interface; inactive activity ignored.
// - Mode 0,0: sample rising, shift falling.
// - Mode 1,1: same edges, clock idles high.
// - Normal and high-voltage select behave alike.
// - Increment/decrement 8 bits; read/write 16.
// - Command byte: address, opcode, data bit 8.
// - Opcode 11 read, 00 write, 01/10 step.
// - Steps invalid at terminal-connect addresses.
// - Six ones, error flag, then read data.
// - Six mapped addresses; others reserved.
// - Registers hold nine bits; top dropped.
// - Valid pairing flag high, otherwise low.
// - Clock level at select picks mode.
// - Read returns nine bits, MSB first.
// - Step saturates at full and zero scale.
// - After error ignore commands, output low.
module qp_device (
	input wire logic i_clk, // System clock, 200 MHz.
	input wire logic i_rst_b, // Asynchronous reset, active low.
	qp_if.device bus, // Serial link.
	output logic [8:0] o_wiper0, // Wiper register 0.
	output logic [8:0] o_wiper1, // Wiper register 1.
	output logic [8:0] o_wiper2, // Wiper register 2.
	output logic [8:0] o_wiper3, // Wiper register 3.
	output logic [8:0] o_tcon0, // Terminal connect register 0.
	output logic [8:0] o_tcon1, // Terminal connect register 1.
	output logic o_mode11, // Mode 1,1 latched at select.
	output logic o_hv // Current frame is high-voltage.
);
	logic [1:0] cs_s, sck_s, mosi_s, hv_s;
	logic cs_q, sck_q, active, err;
	logic [4:0] cnt;
	logic [7:0] cmd;
	logic [7:0] dat;
	logic [8:0] rd_shift;

	// Two-flop synchronisers for all link inputs.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cs_s <= 2'h3;
			sck_s <= 2'h0;
			mosi_s <= 2'h0;
			hv_s <= 2'h0;
		end else begin
			cs_s <= {cs_s[0], bus.cs_b};
			sck_s <= {sck_s[0], bus.sck};
			mosi_s <= {mosi_s[0], bus.mosi};
			hv_s <= {hv_s[0], bus.cs_hv};
		end
	end

	// Edge and framing decode on synchronised signals.
	wire cs_now = ~cs_s[1];
	wire sck_now = sck_s[1];
	wire sel_rise = cs_now & ~cs_q;
	wire rise = active & sck_now & ~sck_q;
	wire fall = active & ~sck_now & sck_q;
	wire [4:0] pos = (cnt >= qp_pkg::BITS_LONG) ? 5'h00 : cnt;
	wire [4:0] pos_n = pos + 5'h01;
	wire [7:0] cmd_n = {cmd[6:0], mosi_s[1]};
	// At the sixth bit the address and opcode still sit two places low.
	wire [3:0] adr = cmd_n[qp_pkg::ADDR_HI - 2:qp_pkg::ADDR_LO - 2];
	wire [1:0] opc = cmd_n[qp_pkg::OPC_HI - 2:qp_pkg::OPC_LO - 2];
	// Command byte aligned for the bit now handled, before it is complete.
	wire [7:0] cmd_f = (pos >= qp_pkg::BITS_SHORT) ? cmd
		: (rise ? cmd_n : {cmd[6:0], 1'b0});
	wire [1:0] opc_q = cmd_f[qp_pkg::OPC_HI:qp_pkg::OPC_LO];
	wire [3:0] adr_q = cmd_f[qp_pkg::ADDR_HI:qp_pkg::ADDR_LO];
	// Address and opcode validity decode.
	wire is_wiper = (adr == qp_pkg::ADR_WIPER0) | (adr == qp_pkg::ADR_WIPER1)
		| (adr == qp_pkg::ADR_WIPER2) | (adr == qp_pkg::ADR_WIPER3);
	wire is_terminal_connect_reg = (adr == qp_pkg::ADR_TCON0) | (adr == qp_pkg::ADR_TCON1);
	wire is_step = (opc == qp_pkg::OPC_INCR) | (opc == qp_pkg::OPC_DECR);
	wire valid = is_wiper | (is_terminal_connect_reg & ~is_step);
	wire [1:0] opc_n = cmd_n[qp_pkg::OPC_HI:qp_pkg::OPC_LO];
	wire short_n = (opc_n == qp_pkg::OPC_INCR) | (opc_n == qp_pkg::OPC_DECR);
	wire last_bit = ((pos_n == qp_pkg::BITS_SHORT) & short_n)
		| (pos_n == qp_pkg::BITS_LONG);
	// Latest bit completes the opcode at position 6 (sixth bit in).
	wire opc_done = (pos_n == qp_pkg::ERR_BIT);

	// Current register selected by the address field held in cmd.
	logic [8:0] cur;
	always_comb begin
		unique case (adr_q)
			qp_pkg::ADR_WIPER0: cur = o_wiper0;
			qp_pkg::ADR_WIPER1: cur = o_wiper1;
			qp_pkg::ADR_WIPER2: cur = o_wiper2;
			qp_pkg::ADR_WIPER3: cur = o_wiper3;
			qp_pkg::ADR_TCON0: cur = o_tcon0;
			qp_pkg::ADR_TCON1: cur = o_tcon1;
			default: cur = 9'h000;
		endcase
	end
	wire [8:0] inc_v = (cur >= qp_pkg::FULL_SCALE) ? cur : cur + 9'h001;
	wire [8:0] dec_v = ((cur == qp_pkg::ZERO_SCALE)
		| (cur > qp_pkg::FULL_SCALE)) ? cur : cur - 9'h001;
	wire [8:0] wr_v = {cmd[qp_pkg::D8_POS - 1], dat[6:0], mosi_s[1]};
	// Commit strobe and value, only on the final clock of the command.
	wire commit = rise & ~err & (pos >= qp_pkg::BITS_SHORT - 5'h01)
		& last_bit & (opc_q != qp_pkg::OPC_READ);
	wire [8:0] new_v = (opc_q == qp_pkg::OPC_WRITE) ? wr_v
		: (opc_q == qp_pkg::OPC_INCR) ? inc_v : dec_v;

	// Framing, counter, error and shift state.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cs_q <= 1'b0;
			sck_q <= 1'b0;
			active <= 1'b0;
			err <= 1'b0;
			cnt <= 5'h00;
			cmd <= 8'h00;
			dat <= 8'h00;
			o_mode11 <= 1'b0;
			o_hv <= 1'b0;
		end else begin
			cs_q <= cs_now;
			sck_q <= sck_now;
			if (!cs_now) begin
				active <= 1'b0;
				err <= 1'b0;
				cnt <= 5'h00;
			end else if (sel_rise) begin
				active <= 1'b1;
				cnt <= 5'h00;
				o_mode11 <= sck_now;
				o_hv <= hv_s[1];
			end else if (rise && !err) begin
				if (pos < qp_pkg::BITS_SHORT) begin
					cmd <= cmd_n;
				end else begin
					dat <= {dat[6:0], mosi_s[1]};
				end
				if (opc_done && !valid) begin
					err <= 1'b1;
				end
				cnt <= last_bit ? 5'h00 : pos_n;
			end
		end
	end

	// Serial output: ones, error flag, read data, changed on falling edges.
	wire [4:0] rd_go_lim = qp_pkg::ERR_BIT + 5'h01;
	wire rd_go = (cnt == rd_go_lim) & (opc_q == qp_pkg::OPC_READ);
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bus.miso <= 1'b1;
			bus.miso_oe <= 1'b0;
			rd_shift <= 9'h000;
		end else if (!cs_now) begin
			bus.miso <= 1'b1;
			bus.miso_oe <= 1'b0;
		end else if (sel_rise) begin
			bus.miso <= 1'b1;
			bus.miso_oe <= 1'b1;
		end else if (fall) begin
			if (err) begin
				bus.miso <= 1'b0;
			end else if (rd_go) begin
				bus.miso <= cur[8];
				rd_shift <= {cur[7:0], 1'b0};
			end else if (opc_q == qp_pkg::OPC_READ && cnt > rd_go_lim) begin
				bus.miso <= rd_shift[8];
				rd_shift <= {rd_shift[7:0], 1'b0};
			end else begin
				bus.miso <= 1'b1;
			end
		end
	end

	// Register file with per-register write enables.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wiper0 <= qp_pkg::WIPER_RESET;
			o_wiper1 <= qp_pkg::WIPER_RESET;
			o_wiper2 <= qp_pkg::WIPER_RESET;
			o_wiper3 <= qp_pkg::WIPER_RESET;
			o_tcon0 <= qp_pkg::TERMINAL_CONNECT_REG_RESET;
			o_tcon1 <= qp_pkg::TERMINAL_CONNECT_REG_RESET;
		end else if (commit) begin
			unique case (adr_q)
				qp_pkg::ADR_WIPER0: o_wiper0 <= new_v;
				qp_pkg::ADR_WIPER1: o_wiper1 <= new_v;
				qp_pkg::ADR_WIPER2: o_wiper2 <= new_v;
				qp_pkg::ADR_WIPER3: o_wiper3 <= new_v;
				qp_pkg::ADR_TCON0: o_tcon0 <= wr_v;
				qp_pkg::ADR_TCON1: o_tcon1 <= wr_v;
				default: ;
			endcase
		end
	end
endmodule // qp_device

// ==== logic/qp_master.sv ====
`timescale 1ns/1ps
module qp_master (
	input wire logic i_clk, // System clock, 200 MHz.
	input wire logic i_rst_b, // Asynchronous reset, active low.
	qp_if.master bus, // Serial link.
	input wire logic [3:0] i_addr, // Register address of command.
	input wire logic [7:0] i_wdata, // Command data word.
	input wire logic i_wr, // Write strobe.
	input wire logic i_rd, // Read strobe.
	output logic [15:0] o_rdata // Read data, one cycle after strobe.
);
	// Software registers: 0 command, 1 data, 2 status, 3 last response.
	localparam logic [3:0] R_CMD = 4'h0;
	localparam logic [3:0] R_DATA = 4'h1;
	localparam logic [3:0] R_STAT = 4'h2;
	localparam logic [3:0] R_RESP = 4'h3;
	typedef enum logic [3:0] {
		QP_IDLE = 4'h1, QP_LEAD = 4'h2, QP_SHIFT = 4'h4, QP_END = 4'h8
	} qp_state_t;
	qp_state_t st;
	logic [7:0] cmd_reg, data_reg, tmr;
	logic [1:0] cfg; // Bit 0 mode 1,1 idle, bit 1 high-voltage select.
	logic [15:0] sh, resp;
	logic [4:0] nb, done_b;
	logic [1:0] miso_s;
	logic ph;
	wire go = i_wr & (i_addr == R_CMD) & (st == QP_IDLE);
	wire is_short = (i_wdata[3:2] == qp_pkg::OPC_INCR)
		| (i_wdata[3:2] == qp_pkg::OPC_DECR);
	wire tick = (tmr == 8'h00);

	// Read data path for software.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			unique case (i_addr)
				R_CMD: o_rdata <= {8'h00, cmd_reg};
				R_DATA: o_rdata <= {8'h00, data_reg};
				R_STAT: o_rdata <= {13'h0000, cfg, st != QP_IDLE};
				R_RESP: o_rdata <= resp;
				default: o_rdata <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			miso_s <= 2'h3;
		end else begin
			miso_s <= {miso_s[0], bus.miso};
		end
	end

	// Frame sequencer; writing the command register starts a frame.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= QP_IDLE;
			cmd_reg <= 8'h00;
			data_reg <= 8'h00;
			cfg <= 2'h0;
			sh <= 16'h0000;
			resp <= 16'h0000;
			nb <= 5'h00;
			done_b <= 5'h00;
			tmr <= 8'h00;
			ph <= 1'b0;
			bus.cs_b <= 1'b1;
			bus.cs_hv <= 1'b0;
			bus.sck <= 1'b0;
			bus.mosi <= 1'b0;
		end else begin
			if (i_wr && i_addr == R_DATA) data_reg <= i_wdata;
			if (i_wr && i_addr == R_STAT) cfg <= i_wdata[2:1];
			tmr <= tick ? 8'h00 : tmr - 8'h01;
			unique case (st)
				QP_IDLE: begin
					bus.sck <= cfg[0];
					if (go) begin
						cmd_reg <= i_wdata;
						sh <= {i_wdata, data_reg};
						nb <= is_short ? qp_pkg::BITS_SHORT : qp_pkg::BITS_LONG;
						done_b <= 5'h00;
						bus.cs_b <= 1'b0;
						bus.cs_hv <= cfg[1];
						tmr <= 8'(qp_pkg::LEAD_CYC);
						st <= QP_LEAD;
					end
				end
				QP_LEAD: if (tick) begin
					bus.mosi <= sh[15];
					bus.sck <= 1'b0;
					ph <= 1'b0;
					tmr <= 8'(qp_pkg::SCK_HALF_CYC);
					st <= QP_SHIFT;
				end
				QP_SHIFT: if (tick) begin
					tmr <= 8'(qp_pkg::SCK_HALF_CYC);
					ph <= ~ph;
					if (!ph) begin
						bus.sck <= 1'b1;
						resp <= {resp[14:0], miso_s[1]};
						done_b <= done_b + 5'h01;
					end else begin
						bus.sck <= 1'b0;
						sh <= {sh[14:0], 1'b0};
						bus.mosi <= sh[14];
						if (done_b == nb) st <= QP_END;
					end
				end
				QP_END: if (tick) begin
					bus.cs_b <= 1'b1;
					bus.cs_hv <= 1'b0;
					bus.sck <= cfg[0];
					st <= QP_IDLE;
				end
				default: st <= QP_IDLE;
			endcase
		end
	end
endmodule // qp_master

// ==== verif/qp_assertions.sv ====
`timescale 1ns/1ps
module qp_assertions (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_b, // Reset, active low.
	input wire logic cs_b, // Select, active low.
	input wire logic cs_hv, // High-voltage select.
	input wire logic sck, // Serial clock.
	input wire logic mosi, // Data to device.
	input wire logic miso, // Data from device.
	input wire logic miso_oe // Device drives miso.
);
	logic sck_q;
	logic [4:0] cnt;
	logic [3:0] since;
	logic [5:0] sh;
	// Frame state, clock edges and the expected error flag.
	wire sel = !cs_b || cs_hv;
	wire rise = sck && !sck_q;
	wire fall = !sck && sck_q;
	wire [3:0] adr = sh[5:2];
	wire wip = adr == 4'h0 || adr == 4'h1 || adr == 4'h6 || adr == 4'h7;
	wire tcn = adr == 4'h4 || adr == 4'hA;
	wire valid = wip || (tcn && (sh[1:0] == 2'h0 || sh[1:0] == 2'h3));
	wire at_flag = sel && cnt == 5'h06 && since == 4'h6;
	// Count bits in, shift the command in, and time since the last fall.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sck_q <= 1'b0;
			cnt <= 5'h00;
			since <= 4'hF;
			sh <= 6'h00;
		end else begin
			sck_q <= sck;
			since <= fall ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
			cnt <= !sel ? 5'h00 : (rise ? cnt + 5'h01 : cnt);
			sh <= (sel && rise) ? {sh[4:0], mosi} : sh;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	property p_on; $rose(sel) |-> ##[1:4] miso_oe; endproperty
	a_on: assert property (p_on) else $error("no drive after select");
	property p_off; $fell(sel) |-> ##[1:4] !miso_oe; endproperty
	a_off: assert property (p_off) else $error("drive after deselect");
	property p_ones; sel && miso_oe && cnt < 5'h06 && since > 4'h4 |-> miso;
	endproperty
	a_ones: assert property (p_ones) else $error("leading bit not one");
	property p_flag; at_flag |-> miso == valid; endproperty
	a_flag: assert property (p_flag) else $error("wrong error flag");
	property p_hold; at_flag && !miso |=> (!miso || !sel) [*8]; endproperty
	a_hold: assert property (p_hold) else $error("error not held");
	property p_edge; sel && cnt != 5'h00 && $changed(miso) |-> since < 4'h5;
	endproperty
	a_edge: assert property (p_edge) else $error("output off fall");
	property p_lead; $rose(sel) |-> $stable(sck) [*8]; endproperty
	a_lead: assert property (p_lead) else $error("clock too soon");
	property p_len; $fell(sel) |-> cnt == 5'h08 || cnt == 5'h10; endproperty
	a_len: assert property (p_len) else $error("bad frame length");
endmodule // qp_assertions

// ==== verif/test_quad_pot_spi_command_port.sv ====
`timescale 1ns/1ps
module test_quad_pot_spi_command_port;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	logic [8:0] o_wiper0, o_wiper1, o_wiper2, o_wiper3, o_tcon0, o_tcon1;
	logic o_mode11, o_hv;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	qp_if bus ();
	qp_master u_qp_master (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata));
	qp_device u_qp_device (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus),
		.o_wiper0(o_wiper0), .o_wiper1(o_wiper1), .o_wiper2(o_wiper2),
		.o_wiper3(o_wiper3), .o_tcon0(o_tcon0), .o_tcon1(o_tcon1),
		.o_mode11(o_mode11), .o_hv(o_hv));
	qp_assertions u_qp_assertions (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.cs_b(bus.cs_b), .cs_hv(bus.cs_hv), .sck(bus.sck), .mosi(bus.mosi),
		.miso(bus.miso), .miso_oe(bus.miso_oe));
	// Clock and a cycle ceiling that cuts a hang short.
	always #2.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end
	task automatic results();
		$display("Checks %0d, errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic note(input logic bad);
		checks_done++;
		if (bad) begin
			fail_count++;
			$display("ERROR %0t: mismatch", $time);
		end
	endtask
	task automatic check_resp(input logic [15:0] got, input logic [15:0] exp);
		note(got !== exp);
	endtask
	task automatic check_reg(input logic [8:0] got, input logic [8:0] exp);
		note(got !== exp);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// One command frame; waits for the busy bit, then fetches the response.
	task automatic frame(input logic [7:0] c, input logic [7:0] d,
		output logic [15:0] r);
		logic [15:0] st;
		int n;
		n = 0;
		wr(4'h1, d);
		wr(4'h0, c);
		do begin
			rd(4'h2, st);
			n++;
		end while (st[0] !== 1'b0 && n < 2000);
		if (n >= 2000)
			note(1'b1);
		rd(4'h3, r);
	endtask
	task automatic t_write();
		logic [15:0] r;
		frame(8'h0C, 8'h00, r);
		check_resp(r, 16'hFE80);
		frame(8'h63, 8'h23, r);
		check_resp(r, 16'hFFFF);
		check_reg(o_wiper2, 9'h123);
		frame(8'hA0, 8'h55, r);
		check_reg(o_tcon1, 9'h055);
	endtask
	task automatic t_step();
		logic [15:0] r;
		frame(8'h11, 8'h00, r);
		frame(8'h14, 8'h00, r);
		check_resp({8'h00, r[7:0]}, 16'h00FF);
		check_reg(o_wiper1, 9'h100);
		frame(8'h18, 8'h00, r);
		check_reg(o_wiper1, 9'h0FF);
		frame(8'h10, 8'h00, r);
		frame(8'h18, 8'h00, r);
		check_reg(o_wiper1, 9'h000);
		frame(8'h14, 8'h00, r);
		check_reg(o_wiper1, 9'h001);
	endtask
	task automatic t_err();
		logic [15:0] r;
		frame(8'h44, 8'h00, r);
		check_resp({8'h00, r[7:0]}, 16'h00FC);
		check_reg(o_tcon0, 9'h1FF);
		frame(8'h2C, 8'h00, r);
		check_resp(r, 16'hFC00);
		frame(8'h30, 8'hFF, r);
		check_resp(r, 16'hFC00);
		check_reg(o_wiper0, 9'h080);
	endtask
	task automatic t_mode();
		logic [15:0] r;
		wr(4'h2, 8'h06);
		frame(8'h6C, 8'h00, r);
		check_resp(r, 16'hFF23);
		check_reg({7'h00, o_mode11, o_hv}, 9'h003);
		wr(4'h2, 8'h00);
		frame(8'h6C, 8'h00, r);
		check_resp(r, 16'hFF23);
		check_reg({7'h00, o_mode11, o_hv}, 9'h000);
	endtask
	// Reset, then the scenarios in turn.
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_write();
		t_step();
		t_err();
		t_mode();
		results();
	end
endmodule // test_quad_pot_spi_command_port
